// ===== css_charge_stage_sequencer.v
// Charge stage sequencer with LED indication and Wishbone settings port
`timescale 1ns/1ps
`include "css_regs.vh"

module css_charge_stage_sequencer #(
    parameter [15:0] MS_CYCLES = `CSS_MS_CYC,
    parameter [15:0] MS_PER_S  = `CSS_S_MS
)(
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Measurements, mV and mA
    input  wire [15:0] pv_mv,
    input  wire [15:0] bat_mv,
    input  wire [15:0] bat_ma,
    input  wire        sys_24v,
    input  wire [2:0]  rotary_pos,
    // Fault sources
    input  wire        over_temp,
    input  wire        over_current,
    input  wire        over_voltage,
    input  wire        cal_lost,
    input  wire        settings_lost,
    input  wire        current_sensor_fault,
    // External charge control
    input  wire        energy_storage_system_mode,
    input  wire [15:0] ext_curve_mv,
    input  wire        bat_limit_valid,
    input  wire [15:0] battery_charge_voltage_limit,
    // Charger control and LEDs
    output reg         charge_en,
    output reg  [15:0] target_mv,
    output reg  [7:0]  temperature_slope,
    output reg  [2:0]  stage,
    output reg         led_bulk,
    output reg         led_abs,
    output reg         led_float
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_BULK  = 3'h1;
    localparam [2:0] ST_ABS   = 3'h2;
    localparam [2:0] ST_EQ    = 3'h3;
    localparam [2:0] ST_FLOAT = 3'h4;
    localparam [2:0] ST_EXT   = 3'h5;

    // Profile table on 24V basis: 0 absorption, 1 float, 2 equalize
    function [15:0] prof;
        input [2:0] pos;
        input [1:0] kind;
        begin
            case (kind)
                2'h1: prof = (pos == 3'h7) ? 16'h6978 : 16'h6BD0;
                2'h2:
                    case (pos)
                        3'h0: prof = 16'h7C38;
                        3'h1: prof = 16'h7DC8;
                        3'h2: prof = 16'h7E90;
                        3'h3: prof = 16'h80E8;
                        3'h4: prof = 16'h8278;
                        3'h5: prof = 16'h8408;
                        3'h6: prof = 16'h8598;
                        default: prof = 16'h0000;
                    endcase
                default:
                    case (pos)
                        3'h0: prof = 16'h6E28;
                        3'h1: prof = 16'h6FB8;
                        3'h2: prof = 16'h7080;
                        3'h3: prof = 16'h72D8;
                        3'h4: prof = 16'h7468;
                        3'h5: prof = 16'h75F8;
                        3'h6: prof = 16'h7788;
                        default: prof = 16'h6EF0;
                    endcase
            endcase
        end
    endfunction

    // Scale a 24V basis value to the running system voltage
    function [15:0] sysv;
        input [15:0] v;
        input        is24;
        begin
            sysv = is24 ? v : {1'b0, v[15:1]};
        end
    endfunction

    // Settings and state
    reg  [1:0]  ctrl_reg;
    reg  [15:0] r_abs_reg;
    reg  [15:0] r_float_reg;
    reg  [15:0] r_eq_reg;
    reg  [3:0]  r_mult_reg;
    reg  [15:0] r_tail_reg;
    reg  [4:0]  valid_reg;
    reg  [3:0]  day_mult_reg;
    reg  [2:0]  st_reg;
    reg         run_reg;
    reg  [15:0] tmr_reg;
    reg  [15:0] stop_reg;
    reg  [15:0] low_reg;
    reg  [15:0] ms_cnt_reg;
    reg  [15:0] ms_in_s_reg;
    reg  [15:0] s3_reg;
    reg  [15:0] s_free_reg;
    reg  [7:0]  fast_reg;
    reg  [15:0] code_reg;
    reg  [2:0]  sw_prev_reg;
    reg         init_reg;

    wire ms_tick  = (ms_cnt_reg == MS_CYCLES - 16'h0001);
    wire sec_tick = ms_tick && (ms_in_s_reg == MS_PER_S - 16'h0001);
    wire sw_chg   = init_reg && (rotary_pos != sw_prev_reg);
    wire [16:0] pv17  = {1'b0, pv_mv};
    wire [16:0] bat17 = {1'b0, bat_mv};
    wire pv_present   = pv_mv > bat_mv;

    // Effective settings: remote value wins while its valid bit stands
    wire [15:0] abs_v   = valid_reg[0] ? r_abs_reg : sysv(prof(rotary_pos, 2'h0), sys_24v);
    wire [15:0] float_v = valid_reg[1] ? r_float_reg : sysv(prof(rotary_pos, 2'h1), sys_24v);
    wire [15:0] eq_v    = valid_reg[2] ? r_eq_reg : sysv(prof(rotary_pos, 2'h2), sys_24v);
    wire [3:0]  mult    = valid_reg[3] ? r_mult_reg : day_mult_reg;
    wire [15:0] tail    = valid_reg[4] ? r_tail_reg : `CSS_TAIL_DEF;
    wire [15:0] abs_lim = {12'h000, mult} * `CSS_HOUR_S;
    wire        eq8     = (rotary_pos < 3'h4);
    wire [15:0] bat12   = sys_24v ? {1'b0, bat_mv[15:1]} : bat_mv;
    wire [15:0] delta   = ctrl_reg[`CSS_CTRL_LFP] ? `CSS_LFP_DELTA : `CSS_LA_DELTA;
    wire [15:0] delta_s = sys_24v ? {delta[14:0], 1'b0} : delta;
    wire        paused  = (st_reg == ST_ABS) && (bat_mv < abs_v);
    wire        ext_on  = energy_storage_system_mode || bat_limit_valid;
    wire        eq_has  = ctrl_reg[`CSS_CTRL_EQ] && (eq_v != 16'h0000);

    // Millisecond and second time base, free running
    always @(posedge clk)
    begin
        if (reset)
        begin
            ms_cnt_reg  <= 16'h0000;
            ms_in_s_reg <= 16'h0000;
            s3_reg      <= 16'h0000;
            s_free_reg  <= 16'h0000;
            fast_reg    <= 8'h00;
        end
        else
        begin
            ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
            if (ms_tick)
            begin
                fast_reg    <= fast_reg + 8'h01;
                ms_in_s_reg <= sec_tick ? 16'h0000 : ms_in_s_reg + 16'h0001;
            end
            if (sec_tick)
            begin
                s_free_reg <= s_free_reg + 16'h0001;
                s3_reg <= (s3_reg == `CSS_PULSE_S - 16'h0001) ? 16'h0000 : s3_reg + 16'h0001;
            end
        end
    end

    // PV gating with start and hold margins
    always @(posedge clk)
    begin
        if (reset)
            run_reg <= 1'b0;
        else if (!run_reg)
            run_reg <= pv17 > bat17 + `CSS_START_MV;
        else
            run_reg <= pv17 > bat17 + `CSS_RUN_MV;
    end

    // Wishbone slave; one wait state, unmapped reads zero
    // Writes land at the edge the master sees ack, so an aborted cycle stores nothing
    wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire [7:0] wb_a = {wb_adr_i[7:2], 2'b00};

    function [15:0] lanes;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    // Switch tracking and remote settings; switch change clears the remote valid bits, ctrl_reg stays
    always @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_reg    <= `CSS_CTRL_RST;
            r_abs_reg   <= 16'h0000;
            r_float_reg <= 16'h0000;
            r_eq_reg    <= 16'h0000;
            r_mult_reg  <= 4'h0;
            r_tail_reg  <= 16'h0000;
            valid_reg   <= 5'h00;
            sw_prev_reg <= 3'h0;
            init_reg    <= 1'b0;
        end
        else
        begin
            init_reg    <= 1'b1;
            sw_prev_reg <= rotary_pos;
            if (wb_wr && wb_a == `CSS_ADR_CTRL && wb_sel_i[0])
                ctrl_reg <= wb_dat_i[1:0];
            if (sw_chg)
                valid_reg <= 5'h00;
            else if (wb_wr)
            begin
                case (wb_a)
                    `CSS_ADR_ABS:
                    begin
                        r_abs_reg    <= lanes(r_abs_reg, wb_dat_i, wb_sel_i);
                        valid_reg[0] <= 1'b1;
                    end
                    `CSS_ADR_FLOAT:
                    begin
                        r_float_reg  <= lanes(r_float_reg, wb_dat_i, wb_sel_i);
                        valid_reg[1] <= 1'b1;
                    end
                    `CSS_ADR_EQ:
                    begin
                        r_eq_reg     <= lanes(r_eq_reg, wb_dat_i, wb_sel_i);
                        valid_reg[2] <= 1'b1;
                    end
                    `CSS_ADR_MULT:
                        if (wb_sel_i[0])
                        begin
                            r_mult_reg   <= wb_dat_i[3:0];
                            valid_reg[3] <= 1'b1;
                        end
                    `CSS_ADR_TAIL:
                    begin
                        r_tail_reg   <= lanes(r_tail_reg, wb_dat_i, wb_sel_i);
                        valid_reg[4] <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Stage sequencer
    always @(posedge clk)
    begin
        if (reset)
        begin
            st_reg       <= ST_IDLE;
            tmr_reg      <= 16'h0000;
            stop_reg     <= 16'h0000;
            low_reg      <= 16'h0000;
            day_mult_reg <= `CSS_MULT_X1;
        end
        else if (ext_on)
        begin
            st_reg   <= ST_EXT;
            tmr_reg  <= 16'h0000;
            stop_reg <= 16'h0000;
        end
        else
        begin
            // Too little PV or a held absorption timer counts toward a full reset
            if (sec_tick)
            begin
                if (st_reg != ST_IDLE && (paused || !run_reg))
                    stop_reg <= stop_reg + 16'h0001;
                else
                    stop_reg <= 16'h0000;
            end
            case (st_reg)
                ST_IDLE:
                    if (run_reg)
                    begin
                        st_reg <= ST_BULK;
                        if (bat12 < `CSS_VB1_MV)
                            day_mult_reg <= `CSS_MULT_X1;
                        else if (bat12 < `CSS_VB2_MV)
                            day_mult_reg <= `CSS_MULT_X23;
                        else if (bat12 < `CSS_VB3_MV)
                            day_mult_reg <= `CSS_MULT_X13;
                        else
                            day_mult_reg <= `CSS_MULT_X16;
                    end
                ST_BULK:
                    if (run_reg && bat_mv >= abs_v)
                    begin
                        st_reg  <= ST_ABS;
                        tmr_reg <= 16'h0000;
                    end
                ST_ABS:
                    if (!paused && (tmr_reg >= abs_lim || bat_ma < tail))
                    begin
                        st_reg  <= eq_has ? ST_EQ : ST_FLOAT;
                        tmr_reg <= 16'h0000;
                        low_reg <= 16'h0000;
                    end
                    else if (sec_tick && !paused)
                        tmr_reg <= tmr_reg + 16'h0001;
                ST_EQ:
                    if ((eq8 && bat_mv >= eq_v) ||
                        tmr_reg >= (eq8 ? `CSS_EQ8_S : `CSS_EQ_S))
                    begin
                        st_reg  <= ST_FLOAT;
                        low_reg <= 16'h0000;
                    end
                    else if (sec_tick)
                        tmr_reg <= tmr_reg + 16'h0001;
                ST_FLOAT:
                    if ({1'b0, bat_mv} + {1'b0, delta_s} >= {1'b0, float_v})
                        low_reg <= 16'h0000;
                    else if (low_reg >= `CSS_RESTART_S)
                    begin
                        st_reg  <= ST_BULK;
                        low_reg <= 16'h0000;
                    end
                    else if (sec_tick)
                        low_reg <= low_reg + 16'h0001;
                ST_EXT:
                    st_reg <= ST_IDLE;
                default:
                    st_reg <= ST_IDLE;
            endcase
            if (stop_reg >= `CSS_STOP_S)
            begin
                st_reg   <= ST_IDLE;
                tmr_reg  <= 16'h0000;
                stop_reg <= 16'h0000;
            end
        end
    end

    // Position display window, cancelled when PV goes away
    always @(posedge clk)
    begin
        if (reset)
            code_reg <= 16'h0000;
        else if (!pv_present)
            code_reg <= 16'h0000;
        else if (sw_chg)
            code_reg <= `CSS_CODE_MS;
        else if (ms_tick && code_reg != 16'h0000)
            code_reg <= code_reg - 16'h0001;
    end

    // Fault priority and LED pattern selection
    wire int_err = cal_lost || settings_lost || current_sensor_fault;
    reg  [2:0] fault_code;
    reg  [2:0] leds;
    wire slow  = ms_in_s_reg < {1'b0, MS_PER_S[15:1]};
    wire vslow = s_free_reg[1];
    wire fast  = fast_reg[6];
    always @*
    begin
        fault_code = 3'h0;
        if (over_temp)
            fault_code = 3'h1;
        else if (over_current)
            fault_code = 3'h2;
        else if (over_voltage)
            fault_code = 3'h3;
        else if (int_err)
            fault_code = 3'h4;
        case (fault_code)
            3'h1: leds = 3'b101;
            3'h2: leds = 3'b110;
            3'h3: leds = 3'b011;
            3'h4: leds = {3{fast}};
            default:
                if (code_reg != 16'h0000)
                begin
                    if (sw_prev_reg == 3'h0)
                        leds = {3{fast}};
                    else
                        leds = sw_prev_reg & {3{slow}};
                end
                else if (!run_reg)
                    leds = {s3_reg == 16'h0000 && ms_in_s_reg < `CSS_PULSE_MS, 2'b00};
                else
                    case (st_reg)
                        ST_BULK:  leds = 3'b100;
                        ST_ABS:   leds = {1'b0, paused ? vslow : 1'b1, 1'b0};
                        ST_EQ:    leds = 3'b011;
                        ST_FLOAT: leds = 3'b001;
                        ST_EXT:   leds = 3'b010;
                        default:  leds = 3'b100;
                    endcase
        endcase
    end

    // Charger target; profile slope is zero only for lithium
    always @(posedge clk)
    begin
        if (reset)
        begin
            charge_en         <= 1'b0;
            target_mv         <= 16'h0000;
            temperature_slope <= 8'h00;
            stage             <= ST_IDLE;
            led_bulk          <= 1'b0;
            led_abs           <= 1'b0;
            led_float         <= 1'b0;
        end
        else
        begin
            charge_en         <= run_reg && st_reg != ST_IDLE && fault_code == 3'h0;
            temperature_slope <= (rotary_pos == 3'h7) ? 8'h00 : 8'hE0;
            stage             <= st_reg;
            {led_bulk, led_abs, led_float} <= leds;
            case (st_reg)
                ST_BULK, ST_ABS: target_mv <= abs_v;
                ST_EQ:           target_mv <= eq_v;
                ST_FLOAT:        target_mv <= float_v;
                ST_EXT:          target_mv <= bat_limit_valid ? battery_charge_voltage_limit
                                                              : ext_curve_mv;
                default:         target_mv <= 16'h0000;
            endcase
        end
    end

    // Bus answer and read mux
    always @(posedge clk)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i)
                case (wb_a)
                    `CSS_ADR_CTRL:  wb_dat_o <= {30'h0000_0000, ctrl_reg};
                    `CSS_ADR_ABS:   wb_dat_o <= {16'h0000, abs_v};
                    `CSS_ADR_FLOAT: wb_dat_o <= {16'h0000, float_v};
                    `CSS_ADR_EQ:    wb_dat_o <= {16'h0000, eq_v};
                    `CSS_ADR_MULT:  wb_dat_o <= {28'h000_0000, mult};
                    `CSS_ADR_TAIL:  wb_dat_o <= {16'h0000, tail};
                    `CSS_ADR_STAT:
                        wb_dat_o <= ({29'h0000_0000, st_reg} << `CSS_ST_STAGE) |
                                    ({31'h0000_0000, run_reg} << `CSS_ST_RUN) |
                                    ({31'h0000_0000, paused} << `CSS_ST_PAUSE) |
                                    ({31'h0000_0000, |valid_reg} << `CSS_ST_REMOTE) |
                                    ({29'h0000_0000, leds} << `CSS_ST_LED) |
                                    ({29'h0000_0000, fault_code} << `CSS_ST_FAULT);
                    `CSS_ADR_TIMER: wb_dat_o <= {16'h0000, tmr_reg};
                    default:        wb_dat_o <= 32'h0000_0000;
                endcase
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

endmodule // css_charge_stage_sequencer

// ===== css_regs.vh
// Register map, field layout and timing constants of the charge stage sequencer
`ifndef CSS_REGS_VH
`define CSS_REGS_VH
// Time base
`define CSS_CLK_NS      25
`define CSS_MS_TIME_NS  1000000
`define CSS_MS_CYC      16'h9C40
`define CSS_S_MS        16'h03E8
`define CSS_CODE_MS     16'h0FA0
`define CSS_PULSE_MS    16'h0064
`define CSS_PULSE_S     16'h0003
`define CSS_RESTART_S   16'h003C
`define CSS_STOP_S      16'h0E10
`define CSS_EQ8_S       16'h0E10
`define CSS_EQ_S        16'h3840
`define CSS_HOUR_S      16'h0E10
// PV gating margins in mV
`define CSS_START_MV    17'h0_1388
`define CSS_RUN_MV      17'h0_03E8
// Start-up battery thresholds in mV, 12V basis
`define CSS_VB1_MV      16'h2E7C
`define CSS_VB2_MV      16'h2FA8
`define CSS_VB3_MV      16'h3138
// Absorption multipliers in sixths
`define CSS_MULT_X1     4'h6
`define CSS_MULT_X23    4'h4
`define CSS_MULT_X13    4'h2
`define CSS_MULT_X16    4'h1
// Restart deltas in mV, 12V basis; tail current in mA
`define CSS_LA_DELTA    16'h0190
`define CSS_LFP_DELTA   16'h0064
`define CSS_TAIL_DEF    16'h07D0
// Register byte offsets
`define CSS_ADR_CTRL    8'h00
`define CSS_ADR_ABS     8'h04
`define CSS_ADR_FLOAT   8'h08
`define CSS_ADR_EQ      8'h0C
`define CSS_ADR_MULT    8'h10
`define CSS_ADR_TAIL    8'h14
`define CSS_ADR_STAT    8'h18
`define CSS_ADR_TIMER   8'h1C
// Control fields and reset value
`define CSS_CTRL_EQ     0
`define CSS_CTRL_LFP    1
`define CSS_CTRL_RST    2'h0
// Status fields
`define CSS_ST_STAGE    0
`define CSS_ST_RUN      3
`define CSS_ST_PAUSE    4
`define CSS_ST_REMOTE   5
`define CSS_ST_LED      8
`define CSS_ST_FAULT    12
`endif

// ===== css_seq_chk.sv
// Port assertions of the charge stage sequencer
`timescale 1ns/1ps
module css_seq_chk (
    // Clock and reset
    input wire        clk,
    input wire        reset,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [31:0] wb_dat_o,
    // Measurements and control
    input wire [15:0] pv_mv,
    input wire [15:0] bat_mv,
    input wire        over_temp,
    input wire        bat_limit_valid,
    input wire [15:0] battery_charge_voltage_limit,
    // Outputs watched
    input wire        charge_en,
    input wire [15:0] target_mv,
    input wire [2:0]  stage,
    input wire        led_bulk,
    input wire        led_abs,
    input wire        led_float
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    // Two cycles of margin: running flag, then enable
    stop_gate_a: assert property ((pv_mv <= bat_mv + 17'h0_03E8) [*3] |-> !charge_en)
        else $error("charging with too little PV");
    temp_block_a: assert property (over_temp |=> !charge_en)
        else $error("charging during over temperature");
    temp_led_a: assert property (over_temp [*3] |-> {led_bulk, led_abs, led_float} == 3'b101)
        else $error("wrong temperature fault pattern");
    ext_stage_a: assert property (bat_limit_valid [*3] |-> stage == 3'h5)
        else $error("own algorithm runs under limit");
    limit_track_a: assert property ((bat_limit_valid && $stable(battery_charge_voltage_limit)) [*3]
        |-> target_mv == battery_charge_voltage_limit)
        else $error("target does not follow limit");
endmodule // css_seq_chk
bind css_charge_stage_sequencer css_seq_chk u_chk (.clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .pv_mv, .bat_mv, .over_temp, .bat_limit_valid,
    .battery_charge_voltage_limit, .charge_en, .target_mv, .stage, .led_bulk, .led_abs,
    .led_float);

// ===== css_far_model.sv
// Battery and PV array seen by the charger
`timescale 1ns/1ps
module css_far_model (
    // Clock and charger output
    input  wire         clk,
    input  wire         charge_en,
    // PV margin over battery, mV
    input  wire  [15:0] margin,
    // Measurements
    output logic [15:0] pv_mv,
    output logic [15:0] bat_mv,
    output logic [15:0] bat_ma
);
    // Battery creeps up while charged; stops at a full level
    initial bat_mv = 16'h5DC0;
    always @(posedge clk)
        if (charge_en && bat_mv < 16'h7080)
            bat_mv <= bat_mv + 16'h0001;
    // Current kept above tail so absorption ends by time only
    assign pv_mv = bat_mv + margin;
    assign bat_ma = charge_en ? 16'h1388 : 16'h0000;
endmodule // css_far_model

// ===== css_charge_stage_sequencer_test.sv
// Self-checking bench of the charge stage sequencer
`timescale 1ns/1ps
`include "css_regs.vh"
module css_charge_stage_sequencer_test;
    logic        clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, s24 = 1, store = 0, lim_ok = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, rd, dat_o, rnd = 32'h8684_a8d2;
    logic [15:0] margin = 16'h0000, curve = 16'h0000, lim = 16'h0000, pv, bat, ma, tgt;
    logic [5:0]  flt = 6'h00;
    logic [2:0]  pos = 3'h2, stg, led;
    logic [7:0]  slope;
    logic        ack, en;
    int          err_count = 0, samples_checked = 0, cycles = 0, i;
    localparam logic [15:0] ABS_TAB [8] = '{16'h6E28, 16'h6FB8, 16'h7080, 16'h72D8,
                                            16'h7468, 16'h75F8, 16'h7788, 16'h6EF0};
    localparam logic [15:0] MG [4] = '{16'h1388, 16'h1389, 16'h03E9, 16'h03E8};
    localparam logic [3:0]  RUN_EXP = 4'b0110;
    localparam logic [2:0]  FLT_LED [3] = '{3'b101, 3'b110, 3'b011};
    always #12.5 clk = ~clk;
    css_charge_stage_sequencer #(.MS_CYCLES(16'h0004), .MS_PER_S(16'h0004)) DUT (
        .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pv_mv(pv), .bat_mv(bat), .bat_ma(ma), .sys_24v(s24), .rotary_pos(pos),
        .over_temp(flt[0]), .over_current(flt[1]), .over_voltage(flt[2]),
        .cal_lost(flt[3]), .settings_lost(flt[4]), .current_sensor_fault(flt[5]),
        .energy_storage_system_mode(store), .ext_curve_mv(curve), .bat_limit_valid(lim_ok),
        .battery_charge_voltage_limit(lim), .charge_en(en), .target_mv(tgt),
        .temperature_slope(slope), .stage(stg), .led_bulk(led[2]), .led_abs(led[1]),
        .led_float(led[0]));
    css_far_model far (.clk(clk), .charge_en(en), .margin(margin), .pv_mv(pv),
        .bat_mv(bat), .bat_ma(ma));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Profile voltage: k picks float, halved on a 12V system
    function automatic logic [31:0] prof(input logic [2:0] p, input logic t, input logic k);
        logic [15:0] v;
        v = k ? (p == 3'h7 ? 16'h6978 : 16'h6BD0) : ABS_TAB[p];
        return t ? v : v >> 1;
    endfunction
    task automatic conclude;
        $display("checked %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // Classic cycle; only the bench timeout ends a wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_count++;
            conclude;
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdc("ctrl", `CSS_ADR_CTRL, 32'h0000_0000);
        rdc("tail", `CSS_ADR_TAIL, 32'h0000_07D0);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        rdc("abs", `CSS_ADR_ABS, prof(3'h2, 1'b1, 1'b0));
        for (i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            wb(1'b1, `CSS_ADR_TAIL, rnd & 32'h0000_ffff);
            rdc("tail", `CSS_ADR_TAIL, rnd & 32'h0000_ffff);
            wb(1'b1, `CSS_ADR_ABS, rnd >> 16);
            rdc("abs", `CSS_ADR_ABS, rnd >> 16);
            pos <= i[2:0];
            rdc("abs", `CSS_ADR_ABS, prof(i[2:0], 1'b1, 1'b0));
            rdc("float", `CSS_ADR_FLOAT, prof(i[2:0], 1'b1, 1'b1));
        end
        s24 <= 1'b0;
        rdc("abs", `CSS_ADR_ABS, prof(3'h7, 1'b0, 1'b0));
        s24 <= 1'b1;
        // Start and hold margins at both sides of each edge
        for (i = 0; i < 4; i++)
        begin
            margin <= MG[i];
            wb(1'b0, `CSS_ADR_STAT, 32'h0000_0000);
            chk("running", RUN_EXP[i], rd[3]);
        end
        margin <= 16'h1770;
        repeat (4) @(posedge clk);
        chk("stage", 32'h0000_0001, stg);
        chk("leds", 32'h0000_0004, led);
        chk("slope", 32'h0000_0000, slope);
        for (i = 0; i < 6; i++)
        begin
            flt <= 6'h01 << i;
            wb(1'b0, `CSS_ADR_STAT, 32'h0000_0000);
            chk("fault", (i < 3) ? i + 1 : 4, rd[14:12]);
            chk("charge_en", 32'h0000_0000, en);
            if (i < 3) chk("leds", FLT_LED[i], led);
        end
        flt <= 6'h00;
        pos <= 3'h2;
        repeat (2) @(posedge clk);
        chk("slope", 32'h0000_00e0, slope);
        rnd = lfsr(rnd);
        {store, curve} <= {1'b1, rnd[15:0]};
        repeat (4) @(posedge clk);
        chk("stage", 32'h0000_0005, stg);
        chk("target", curve, tgt);
        {lim_ok, lim} <= {1'b1, rnd[31:16]};
        repeat (4) @(posedge clk);
        chk("target", lim, tgt);
        lim <= lim ^ 16'h0f0f;
        repeat (4) @(posedge clk);
        chk("target", lim, tgt);
        conclude;
    end
endmodule // css_charge_stage_sequencer_test
